/* rtcd_control.sv */
// rtcd_control: oscillator compensation control and daylight adjustment.
// assumes a plain register port, calendar counters on the same clock that
// give one-second and hour-start ticks, and a main supply sense pin.
// Behaviour
// - five-bit trim sits in low bits of 0Dh, loaded at power-up.
// - writes to 0Dh never change the stored trim.
// - enable set and main supply present: correction every 60 seconds.
// - bits 6:5 of 0Dh select battery-mode compensation.
// - write to 0Dh with enable 1 starts a compensation cycle.
// - registers 0Bh and 0Ch are read-only, writes ignored.
// - time moves forward and back at programmed moments every year.
// - forward month at 15h holds BCD month plus adjust enable.
// - week/day registers hold week, weekday and week/day select bit.
// - hour registers hold plain BCD hour, military bit unused.
// - reverse week may be last week of month.
// - forward-done set on forward, cleared by reverse, reset, disable.
//
// Chosen here: the plain strobed port.
`timescale 1ns/1ps

module rtcd_control (
	input wire logic clock, // 200 MHz
	input wire logic reset_n, // asynchronous, active low
	input wire logic clk_en, // freezes all state while low
	input wire logic [7:0] bus_addr, // register address
	input wire logic [7:0] bus_wdata, // write data
	input wire logic bus_wr, // write strobe
	input wire logic bus_rd, // read strobe
	output logic [7:0] bus_rdata, // read data, cycle after strobe
	input wire logic [rtcd_pkg::TRIM_W-1:0] trim_strap, // trim at power-up
	input wire logic [7:0] init_trim_in, // initial trim value source
	input wire logic [7:0] curvature_in, // curvature coefficient source
	input wire logic supply_present_pin, // main supply sense, async
	input wire logic sec_tick, // one-second pulse
	input wire logic hour_tick, // pulse when a new hour starts
	input wire rtcd_pkg::rtcd_now_t now, // present calendar time
	input wire logic temp_changed, // temperature moved since last
	output logic comp_enable, // temperature sense enable
	output logic [1:0] batt_comp_mode, // battery-mode compensation
	output logic comp_cycle_start, // compensation cycle pulse
	output logic corr_load, // load analog/digital trim correction
	output logic time_forward, // advance time one hour pulse
	output logic time_back, // set time back one hour pulse
	output logic daylight_forward_done // forward adjustment done flag
);
	import rtcd_pkg::*;

	logic [TRIM_W-1:0] trim;
	logic trim_loaded;
	logic sup_s1, sup_s2, sup_s3, supply_ok;
	logic [5:0] sec_cnt;
	logic period_hit;
	logic comp_wr_start;
	rtcd_moment_t fwd, rev;
	rtcd_state_t state;
	logic daylight_adjust_enable;
	logic fwd_match, rev_match;

	function automatic logic [5:0] bcd2bin(input logic [7:0] bcd);
		logic [5:0] tens;
		tens = {2'h0, bcd[7:4]};
		bcd2bin = tens * 6'h0A + {2'h0, bcd[3:0]};
	endfunction : bcd2bin

	function automatic logic [2:0] week_of(input logic [7:0] date);
		logic [5:0] day;
		day = bcd2bin(date);
		week_of = 3'((day - 6'h01) / 6'h07 + 6'h01);
	endfunction : week_of

	function automatic logic moment_hit(input rtcd_moment_t m,
			input rtcd_now_t n);
		logic [2:0] wk;
		logic day_ok;
		wk = m.week_day[WD_WEEK_HI:WD_WEEK_LO];
		if (m.week_day[WD_SELECT_BIT]) begin
			day_ok = (m.week_day[WD_DAY_HI:0] == n.weekday) &&
				((wk == WEEK_LAST) ? n.last_week :
				(wk == week_of(n.date)));
		end else begin
			day_ok = (m.date == n.date);
		end
		// enable bit masked from month, military bit from hour
		moment_hit = (m.month[4:0] == n.month[4:0]) &&
			(m.hour[HOUR_MSB:0] == n.hour[HOUR_MSB:0]) && day_ok;
	endfunction : moment_hit

	function automatic logic addr_wr(input logic [7:0] a, input logic [7:0] t,
			input logic wr);
		addr_wr = wr && (a == t);
	endfunction : addr_wr

	// main supply sense: three stages, change once stages two and three agree
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			sup_s1 <= 1'b0;
			sup_s2 <= 1'b0;
			sup_s3 <= 1'b0;
			supply_ok <= 1'b0;
		end else if (clk_en) begin
			sup_s1 <= supply_present_pin;
			sup_s2 <= sup_s1;
			sup_s3 <= sup_s2;
			if (sup_s2 == sup_s3) begin
				supply_ok <= sup_s3;
			end
		end
	end

	// trim caught once after reset release, never written by the bus
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			trim <= TRIM_RESET;
			trim_loaded <= 1'b0;
		end else if (clk_en && !trim_loaded) begin
			trim <= trim_strap;
			trim_loaded <= 1'b1;
		end
	end

	// compensation control bits; trim field of the write is dropped
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			comp_enable <= COMP_TSE_RESET;
			batt_comp_mode <= COMP_BATT_RESET;
		end else if (clk_en && addr_wr(bus_addr, ADDR_COMP, bus_wr)) begin
			comp_enable <= bus_wdata[COMP_TSE_BIT];
			batt_comp_mode <= bus_wdata[COMP_BATT_HI:COMP_BATT_LO];
		end
	end

	assign comp_wr_start = addr_wr(bus_addr, ADDR_COMP, bus_wr) &&
		bus_wdata[COMP_TSE_BIT];
	assign period_hit = comp_enable && supply_ok && sec_tick &&
		(sec_cnt == CORR_PERIOD_TICKS - 6'h01);

	// seconds counted only while correction is armed
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			sec_cnt <= 6'h00;
		end else if (clk_en) begin
			if (!comp_enable || !supply_ok) begin
				sec_cnt <= 6'h00;
			end else if (sec_tick) begin
				sec_cnt <= period_hit ? 6'h00 : sec_cnt + 6'h01;
			end
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			comp_cycle_start <= 1'b0;
			corr_load <= 1'b0;
		end else if (clk_en) begin
			comp_cycle_start <= comp_wr_start || period_hit;
			corr_load <= (comp_wr_start || period_hit) && temp_changed;
		end
	end

	// daylight moment registers
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			fwd <= '{MOMENT_RESET, MOMENT_RESET, MOMENT_RESET, MOMENT_RESET};
			rev <= '{MOMENT_RESET, MOMENT_RESET, MOMENT_RESET, MOMENT_RESET};
		end else if (clk_en && bus_wr) begin
			case (bus_addr)
				ADDR_FWD_MONTH: begin
					fwd.month <= bus_wdata;
				end
				ADDR_FWD_WEEK_DAY: begin
					fwd.week_day <= bus_wdata;
				end
				ADDR_FWD_DATE: begin
					fwd.date <= bus_wdata;
				end
				ADDR_FWD_HOUR: begin
					fwd.hour <= bus_wdata;
				end
				ADDR_REV_MONTH: begin
					rev.month <= bus_wdata;
				end
				ADDR_REV_WEEK_DAY: begin
					rev.week_day <= bus_wdata;
				end
				ADDR_REV_DATE: begin
					rev.date <= bus_wdata;
				end
				ADDR_REV_HOUR: begin
					rev.hour <= bus_wdata;
				end
				default: begin
					// 0Bh, 0Ch and unmapped writes are dropped
				end
			endcase
		end
	end

	assign daylight_adjust_enable = fwd.month[MONTH_ENABLE_BIT];
	assign fwd_match = hour_tick && moment_hit(fwd, now);
	assign rev_match = hour_tick && moment_hit(rev, now);

	// forward only from standard time, reverse only from daylight time,
	// so the repeated hour after setting back cannot retrigger
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			state <= ST_STANDARD;
			time_forward <= 1'b0;
			time_back <= 1'b0;
		end else if (clk_en) begin
			time_forward <= 1'b0;
			time_back <= 1'b0;
			if (!daylight_adjust_enable) begin
				state <= ST_STANDARD;
			end else begin
				case (state)
					ST_STANDARD: begin
						if (fwd_match) begin
							state <= ST_DAYLIGHT;
							time_forward <= 1'b1;
						end
					end
					ST_DAYLIGHT: begin
						if (rev_match) begin
							state <= ST_STANDARD;
							time_back <= 1'b1;
						end
					end
					default: begin
						state <= ST_STANDARD;
					end
				endcase
			end
		end
	end

	assign daylight_forward_done = (state == ST_DAYLIGHT);

	// read port: data only in the cycle after the strobe
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			bus_rdata <= 8'h00;
		end else if (clk_en) begin
			bus_rdata <= 8'h00;
			if (bus_rd) begin
				case (bus_addr)
					ADDR_INIT_TRIM: bus_rdata <= init_trim_in;
					ADDR_CURVATURE: bus_rdata <= curvature_in;
					ADDR_COMP: bus_rdata <= {comp_enable, batt_comp_mode,
						trim};
					ADDR_FWD_MONTH: bus_rdata <= fwd.month;
					ADDR_FWD_WEEK_DAY: bus_rdata <= fwd.week_day;
					ADDR_FWD_DATE: bus_rdata <= fwd.date;
					ADDR_FWD_HOUR: bus_rdata <= fwd.hour;
					ADDR_REV_MONTH: bus_rdata <= rev.month;
					ADDR_REV_WEEK_DAY: bus_rdata <= rev.week_day;
					ADDR_REV_DATE: bus_rdata <= rev.date;
					ADDR_REV_HOUR: bus_rdata <= rev.hour;
					ADDR_STATUS: bus_rdata <= 8'(daylight_forward_done) <<
						STATUS_FWD_DONE_BIT;
					default: bus_rdata <= 8'h00;
				endcase
			end
		end
	end

	property p_trim_loaded;
		@(posedge clock) disable iff (!reset_n)
		$rose(trim_loaded) |-> trim == $past(trim_strap);
	endproperty
	a_trim_loaded: assert property (p_trim_loaded)
		else $error("trim not taken from strap");

	property p_trim_locked;
		@(posedge clock) disable iff (!reset_n)
		trim_loaded && bus_wr && bus_addr == ADDR_COMP |=> $stable(trim);
	endproperty
	a_trim_locked: assert property (p_trim_locked)
		else $error("trim changed by a write");

	property p_period_bound;
		@(posedge clock) disable iff (!reset_n)
		sec_cnt < CORR_PERIOD_TICKS;
	endproperty
	a_period_bound: assert property (p_period_bound)
		else $error("second count passed the period");

	property p_cycle_needs_enable;
		@(posedge clock) disable iff (!reset_n)
		$past(clk_en) && comp_cycle_start |->
			comp_enable || $past(comp_enable);
	endproperty
	a_cycle_needs_enable: assert property (p_cycle_needs_enable)
		else $error("compensation cycle while disabled");

	property p_batt_mode;
		@(posedge clock) disable iff (!reset_n)
		clk_en && bus_wr && bus_addr == ADDR_COMP |=>
			batt_comp_mode == $past(bus_wdata[6:5]);
	endproperty
	a_batt_mode: assert property (p_batt_mode)
		else $error("battery mode not written");

	property p_write_start;
		@(posedge clock) disable iff (!reset_n)
		clk_en && bus_wr && bus_addr == ADDR_COMP && bus_wdata[7] |=>
			comp_cycle_start && corr_load == $past(temp_changed);
	endproperty
	a_write_start: assert property (p_write_start)
		else $error("write with enable did not start a cycle");

	property p_ro_read;
		@(posedge clock) disable iff (!reset_n)
		clk_en && bus_rd && bus_addr == ADDR_INIT_TRIM |=>
			bus_rdata == $past(init_trim_in);
	endproperty
	a_ro_read: assert property (p_ro_read)
		else $error("initial trim read wrong");

	property p_forward_sets;
		@(posedge clock) disable iff (!reset_n)
		time_forward |-> daylight_forward_done && !time_back;
	endproperty
	a_forward_sets: assert property (p_forward_sets)
		else $error("forward without done flag");

	property p_back_clears;
		@(posedge clock) disable iff (!reset_n)
		$past(clk_en) && time_back |->
			!daylight_forward_done && $past(daylight_forward_done);
	endproperty
	a_back_clears: assert property (p_back_clears)
		else $error("reverse did not clear done flag");

	property p_disabled_quiet;
		@(posedge clock) disable iff (!reset_n)
		clk_en && !daylight_adjust_enable |=>
			!time_forward && !time_back && !daylight_forward_done;
	endproperty
	a_disabled_quiet: assert property (p_disabled_quiet)
		else $error("adjustment while disabled");

	property p_forward_match;
		@(posedge clock) disable iff (!reset_n)
		$past(clk_en) && time_forward |->
			$past(fwd_match) && $past(daylight_adjust_enable);
	endproperty
	a_forward_match: assert property (p_forward_match)
		else $error("time moved forward with no programmed moment");

	property p_back_match;
		@(posedge clock) disable iff (!reset_n)
		$past(clk_en) && time_back |->
			$past(rev_match) && $past(daylight_adjust_enable);
	endproperty
	a_back_match: assert property (p_back_match)
		else $error("time set back with no programmed moment");
endmodule : rtcd_control

/* rtcd_pkg.sv */
// rtcd_pkg: register map, field layout, reset values and carrier types
// for the compensation control and daylight adjustment block.
// assumes one clock domain; time inputs arrive from the calendar counters.
package rtcd_pkg;
	// register offsets
	localparam logic [7:0] ADDR_INIT_TRIM = 8'h0B;
	localparam logic [7:0] ADDR_CURVATURE = 8'h0C;
	localparam logic [7:0] ADDR_COMP = 8'h0D;
	localparam logic [7:0] ADDR_FWD_MONTH = 8'h15;
	localparam logic [7:0] ADDR_FWD_WEEK_DAY = 8'h16;
	localparam logic [7:0] ADDR_FWD_DATE = 8'h17;
	localparam logic [7:0] ADDR_FWD_HOUR = 8'h18;
	localparam logic [7:0] ADDR_REV_MONTH = 8'h19;
	localparam logic [7:0] ADDR_REV_WEEK_DAY = 8'h1A;
	localparam logic [7:0] ADDR_REV_DATE = 8'h1B;
	localparam logic [7:0] ADDR_REV_HOUR = 8'h1C;
	localparam logic [7:0] ADDR_STATUS = 8'h1D;

	// field positions
	localparam int TRIM_W = 5;
	localparam int COMP_TSE_BIT = 7;
	localparam int COMP_BATT_HI = 6;
	localparam int COMP_BATT_LO = 5;
	localparam int MONTH_ENABLE_BIT = 7;
	localparam int WD_SELECT_BIT = 6;
	localparam int WD_WEEK_HI = 5;
	localparam int WD_WEEK_LO = 3;
	localparam int WD_DAY_HI = 2;
	localparam int HOUR_MSB = 5;
	localparam int STATUS_FWD_DONE_BIT = 0;
	localparam logic [2:0] WEEK_LAST = 3'h7;

	// reset values
	localparam logic COMP_TSE_RESET = 1'h0;
	localparam logic [1:0] COMP_BATT_RESET = 2'h0;
	localparam logic [TRIM_W-1:0] TRIM_RESET = 5'h00;
	localparam logic [7:0] MOMENT_RESET = 8'h00;

	// timing: correction period in seconds, counted in one-second ticks
	localparam int CORR_PERIOD_S = 60;
	localparam int SEC_TICK_S = 1;
	localparam logic [5:0] CORR_PERIOD_TICKS = 6'(CORR_PERIOD_S / SEC_TICK_S);

	// one programmed daylight moment
	typedef struct packed {
		logic [7:0] month;
		logic [7:0] week_day;
		logic [7:0] date;
		logic [7:0] hour;
	} rtcd_moment_t;

	// present calendar time from the counters
	typedef struct packed {
		logic [7:0] month;
		logic [7:0] date;
		logic [2:0] weekday;
		logic [7:0] hour;
		logic last_week;
	} rtcd_now_t;

	typedef enum logic [1:0] {
		ST_STANDARD = 2'b01,
		ST_DAYLIGHT = 2'b10
	} rtcd_state_t;
endpackage : rtcd_pkg

/* test_rtcd_control.sv */
// test_rtcd_control: self-checking bench for the compensation control and
// daylight adjustment block; assumes rtcd_pkg and rtcd_control are compiled.
`timescale 1ns/1ps

module test_rtcd_control;
	import rtcd_pkg::*;
	localparam logic [4:0] STRAP = 5'h15;
	localparam logic [7:0] INIT_TRIM = 8'h3A;
	localparam logic [7:0] CURV = 8'hC5;
	localparam logic [7:0] MV [8] = '{8'h84, 8'h48, 8'h00, 8'h02,
		8'h10, 8'h78, 8'h00, 8'h02};
	logic clock = 1'b0;
	logic reset_n = 1'b0;
	logic clk_en = 1'b1;
	logic [7:0] bus_addr = 8'h00;
	logic [7:0] bus_wdata = 8'h00;
	logic bus_wr = 1'b0;
	logic bus_rd = 1'b0;
	logic [7:0] bus_rdata;
	logic supply = 1'b1;
	logic sec_tick = 1'b0;
	logic hour_tick = 1'b0;
	logic temp_changed = 1'b1;
	rtcd_now_t now = '0;
	logic comp_enable;
	logic [1:0] batt_comp_mode;
	logic comp_cycle_start;
	logic corr_load;
	logic time_forward;
	logic time_back;
	logic fwd_done;
	int fails = 0;
	int total_checks = 0;
	int n_cyc = 0;
	int n_ld = 0;
	int n_fwd = 0;
	int n_back = 0;

	always #2.5 clock = ~clock;

	rtcd_control rtcd_control_inst (.clock(clock), .reset_n(reset_n),
		.clk_en(clk_en), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
		.bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
		.trim_strap(STRAP), .init_trim_in(INIT_TRIM),
		.curvature_in(CURV), .supply_present_pin(supply),
		.sec_tick(sec_tick), .hour_tick(hour_tick), .now(now),
		.temp_changed(temp_changed), .comp_enable(comp_enable),
		.batt_comp_mode(batt_comp_mode),
		.comp_cycle_start(comp_cycle_start), .corr_load(corr_load),
		.time_forward(time_forward), .time_back(time_back),
		.daylight_forward_done(fwd_done));

	// pulse counters, so checks do not hinge on the exact output cycle
	always @(posedge clock) begin
		if (comp_cycle_start === 1'b1) n_cyc++;
		if (corr_load === 1'b1) n_ld++;
		if (time_forward === 1'b1) n_fwd++;
		if (time_back === 1'b1) n_back++;
	end

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		bus_wr <= 1'b1;
		bus_addr <= a;
		bus_wdata <= d;
		@(posedge clock);
		bus_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clock);
		bus_rd <= 1'b1;
		bus_addr <= a;
		@(posedge clock);
		bus_rd <= 1'b0;
		#1;
		check(bus_rdata, exp);
	endtask : rd

	task automatic secs(input int n);
		repeat (n) begin
			@(posedge clock);
			sec_tick <= 1'b1;
			@(posedge clock);
			sec_tick <= 1'b0;
		end
		repeat (4) @(posedge clock);
		#1;
	endtask : secs

	// one hour start at the given month, date, hour and last-week flag
	task automatic hr(input logic [7:0] m, input logic [7:0] d,
		input logic [7:0] h, input logic last);
		@(posedge clock);
		now <= '{m, d, 3'h0, h, last};
		hour_tick <= 1'b1;
		@(posedge clock);
		hour_tick <= 1'b0;
		repeat (4) @(posedge clock);
		#1;
	endtask : hr

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : tally_and_finish

	initial begin
		repeat (16) @(posedge clock);
		reset_n <= 1'b1;
		repeat (2) @(posedge clock);
		rd(ADDR_COMP, {3'h0, STRAP});
		wr(ADDR_INIT_TRIM, 8'h00);
		wr(ADDR_CURVATURE, 8'hFF);
		rd(ADDR_INIT_TRIM, INIT_TRIM);
		rd(ADDR_CURVATURE, CURV);
		rd(8'h2E, 8'h00);
		rd(ADDR_STATUS, 8'h00);
		$display("test reset and read-only done");
		// every battery mode, with the trim bits written inverted
		for (int m = 0; m < 4; m++) begin
			wr(ADDR_COMP, {1'b1, 2'(m), ~STRAP});
			rd(ADDR_COMP, {1'b1, 2'(m), STRAP});
			check({6'h00, batt_comp_mode}, 8'(m));
		end
		@(posedge clock);
		temp_changed <= 1'b0;
		wr(ADDR_COMP, 8'h80);
		wr(ADDR_COMP, 8'h60);
		repeat (3) @(posedge clock);
		#1;
		check(8'(n_cyc), 8'h05);
		check(8'(n_ld), 8'h04);
		check({7'h00, comp_enable}, 8'h00);
		$display("test compensation writes done");
		wr(ADDR_COMP, {3'b100, STRAP});
		repeat (3) @(posedge clock);
		#1;
		n_cyc = 0;
		secs(59);
		check(8'(n_cyc), 8'h00);
		secs(1);
		check(8'(n_cyc), 8'h01);
		@(posedge clock);
		supply <= 1'b0;
		secs(64);
		check(8'(n_cyc), 8'h01);
		$display("test periodic correction done");
		for (int i = 0; i < 8; i++) wr(ADDR_FWD_MONTH + 8'(i), MV[i]);
		for (int i = 0; i < 8; i++) rd(ADDR_FWD_MONTH + 8'(i), MV[i]);
		@(posedge clock);
		clk_en <= 1'b0;
		wr(ADDR_FWD_HOUR, 8'h05);
		clk_en <= 1'b1;
		rd(ADDR_FWD_HOUR, 8'h02);
		hr(8'h04, 8'h03, 8'h03, 1'b0);
		check(8'(n_fwd), 8'h00);
		hr(8'h04, 8'h10, 8'h02, 1'b0);
		check(8'(n_fwd), 8'h00);
		hr(8'h04, 8'h03, 8'h02, 1'b0);
		check(8'(n_fwd), 8'h01);
		check({7'h00, fwd_done}, 8'h01);
		rd(ADDR_STATUS, 8'h01);
		hr(8'h04, 8'h03, 8'h02, 1'b0);
		check(8'(n_fwd), 8'h01);
		hr(8'h10, 8'h22, 8'h02, 1'b0);
		check(8'(n_back), 8'h00);
		hr(8'h10, 8'h29, 8'h02, 1'b1);
		check(8'(n_back), 8'h01);
		check({7'h00, fwd_done}, 8'h00);
		$display("test daylight forward and reverse done");
		hr(8'h04, 8'h03, 8'h02, 1'b0);
		check({7'h00, fwd_done}, 8'h01);
		wr(ADDR_FWD_MONTH, 8'h04);
		repeat (2) @(posedge clock);
		#1;
		check({7'h00, fwd_done}, 8'h00);
		hr(8'h04, 8'h03, 8'h02, 1'b0);
		check(8'(n_fwd), 8'h02);
		hr(8'h10, 8'h29, 8'h02, 1'b1);
		check(8'(n_back), 8'h01);
		$display("test daylight disable done");
		// date matching instead of week/day matching
		wr(ADDR_FWD_WEEK_DAY, 8'h00);
		wr(ADDR_FWD_DATE, 8'h15);
		wr(ADDR_FWD_MONTH, 8'h84);
		hr(8'h04, 8'h03, 8'h02, 1'b0);
		check(8'(n_fwd), 8'h02);
		hr(8'h04, 8'h15, 8'h02, 1'b0);
		check(8'(n_fwd), 8'h03);
		check({7'h00, fwd_done}, 8'h01);
		$display("test date matching done");
		// reset in mid-run clears the done flag and reloads the trim
		@(posedge clock);
		reset_n <= 1'b0;
		repeat (2) @(posedge clock);
		reset_n <= 1'b1;
		repeat (2) @(posedge clock);
		#1;
		check({7'h00, fwd_done}, 8'h00);
		rd(ADDR_FWD_MONTH, 8'h00);
		rd(ADDR_COMP, {3'h0, STRAP});
		$display("test reset in mid-run done");
		tally_and_finish();
	end
endmodule : test_rtcd_control
